// ===== rtl/fss_consts.vh
`ifndef FSS_CONSTS_VH
`define FSS_CONSTS_VH
// ---------------------------------------------------------------
// timebase
// ---------------------------------------------------------------
`define FSS_CLK_HZ          25000000
`define FSS_TIMEOUT_MS      1000
`define FSS_TIMEOUT_CYC     ((`FSS_CLK_HZ / 1000) * `FSS_TIMEOUT_MS)
// ---------------------------------------------------------------
// state machine codes
// ---------------------------------------------------------------
`define FSS_ST_INIT         4'h1
`define FSS_ST_PREOP        4'h2
`define FSS_ST_SAFEOP       4'h4
`define FSS_ST_OP           4'h8
// ---------------------------------------------------------------
// sync channel types
// ---------------------------------------------------------------
`define FSS_SCT_MBX_OUT     3'h0
`define FSS_SCT_MBX_IN      3'h1
`define FSS_SCT_PD_OUT      3'h2
`define FSS_SCT_PD_IN       3'h3
// ---------------------------------------------------------------
// error codes: main group in bcd, sub in hex
// ---------------------------------------------------------------
`define FSS_MAIN_81         8'h81
`define FSS_MAIN_82         8'h82
`define FSS_SUB_IN_TMO      4'h8
`define FSS_SUB_OUT_TMO     4'h9
`define FSS_SUB_SYNC        4'ha
`define FSS_SUB_WDOG        4'hb
`define FSS_SUB_SCTYPE      4'hc
`define FSS_SUB_OUTCFG      4'hd
`define FSS_SUB_INCFG       4'he
`define FSS_SUB_WAIT_INIT   4'h1
`define FSS_SUB_WAIT_PREOP  4'h2
`endif

// ===== rtl/fss_refresh_timer.v
`timescale 1ns/100ps
`include "fss_consts.vh"
// counts cycles since the last refresh; restarts on every update
module fss_refresh_timer #(
	parameter LIMIT = `FSS_TIMEOUT_CYC,
	parameter W     = 25
) (
	input  wire ref_clk,
	input  wire reset_n,
	input  wire refresh,
	output reg  expired_q
);
	reg [W-1:0] cnt_q;

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	// saturates at the limit so a stale link keeps the flag steady
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q     <= {W{1'b0}};
			expired_q <= 1'b0;
		end else if (refresh) begin
			cnt_q     <= {W{1'b0}}; // RQ12
			expired_q <= 1'b0;
		end else if (cnt_q >= LIMIT[W-1:0]) begin
			expired_q <= 1'b1;      // RQ12
		end else begin
			cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // fss_refresh_timer

// ===== rtl/fss_supervisor.v
`timescale 1ns/100ps
`include "fss_consts.vh"
// Notes on behaviour
// RQ1: output data stale over 1 s raises error
// RQ2: timeout/sync errors: op drops, lower states kept
// RQ3: output data and clock event misordered raises error
// RQ4: op watchdog timeout falls back to safe_operational_state
// RQ5: preop rejects unknown sync channel type, init
// RQ6: preop invalid output channel config, init
// RQ7: preop invalid input channel config, init
// RQ8: flag waiting for master init request, hold
// RQ9: safe_operational_state/op flag waiting for preop request
// RQ10: input data stale over 1 s raises error
// RQ11: error shown as main group plus hex sub
// RQ12: refresh counter restarts, expires after 1 s
module fss_supervisor #(
	parameter TIMEOUT_CYC = `FSS_TIMEOUT_CYC,
	parameter WDOG_CYC    = 250000
) (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire       req_valid,
	input  wire [3:0] req_state,
	input  wire       rx_pd_update,
	input  wire       tx_pd_update,
	input  wire       dc_event,
	input  wire       cfg_check,
	input  wire [2:0] cfg_type,
	input  wire       cfg_out_valid,
	input  wire       cfg_in_valid,
	input  wire       wait_init,
	input  wire       wait_preop,
	input  wire       err_ack,
	output reg  [3:0] state_q,
	output reg        err_active_q,
	output reg  [7:0] err_main_q,
	output reg  [3:0] err_sub_q,
	output reg        err_prefix_q
);
	localparam ST_INIT   = `FSS_ST_INIT;
	localparam ST_PREOP  = `FSS_ST_PREOP;
	localparam ST_SAFEOP = `FSS_ST_SAFEOP;
	localparam ST_OP     = `FSS_ST_OP;

	wire rx_stale;
	wire tx_stale;
	wire wdog_stale;
	reg  rx_stale_q;
	reg  tx_stale_q;
	reg  wdog_stale_q;
	reg  rx_seen_q;
	reg  dc_seen_q;
	reg  sync_err;
	reg  [3:0] state_d;
	reg  [3:0] sub_d;
	reg  [7:0] main_d;
	reg  raise;
	wire rx_rise;
	wire tx_rise;
	wire wdog_rise;
	wire wdog_hit;
	wire type_known;
	wire cfg_bad;
	wire tmo_masked;

	// ---------------------------------------------------------------
	// refresh timers
	// ---------------------------------------------------------------
	fss_refresh_timer #(.LIMIT(TIMEOUT_CYC), .W(25)) u_rx_tmr (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.refresh   (rx_pd_update),
		.expired_q (rx_stale)
	); // RQ1
	fss_refresh_timer #(.LIMIT(TIMEOUT_CYC), .W(25)) u_tx_tmr (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.refresh   (tx_pd_update),
		.expired_q (tx_stale)
	); // RQ10
	// watchdog only runs in op; held refreshed elsewhere
	fss_refresh_timer #(.LIMIT(WDOG_CYC), .W(25)) u_wd_tmr (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.refresh   (rx_pd_update | (state_q != ST_OP)),
		.expired_q (wdog_stale)
	); // RQ4

	// ---------------------------------------------------------------
	// ordering check between output data and clock events
	// ---------------------------------------------------------------
	// each clock event after the first since reset must be preceded by exactly one data update;
	// two of either kind in a row means one side fell out of step
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_seen_q <= 1'b0;
			dc_seen_q <= 1'b0;
		end else if (dc_event) begin
			rx_seen_q <= 1'b0;
			dc_seen_q <= 1'b1;
		end else if (rx_pd_update) begin
			rx_seen_q <= 1'b1;
		end
	end

	always @* begin
		// a clock event after the first since reset with no fresh data, or data twice before an event
		sync_err = (dc_event & dc_seen_q & ~rx_seen_q & ~rx_pd_update) |
		           (rx_pd_update & rx_seen_q & ~dc_event); // RQ3
	end

	// ---------------------------------------------------------------
	// stale flag edges and the errors that outrank them
	// ---------------------------------------------------------------
	// a timeout edge that loses to a higher error in the same cycle is
	// held back one cycle rather than dropped, so its code still shows
	assign rx_rise    = rx_stale & ~rx_stale_q;
	assign tx_rise    = tx_stale & ~tx_stale_q;
	assign wdog_rise  = wdog_stale & ~wdog_stale_q;
	assign wdog_hit   = wdog_rise & (state_q == ST_OP);
	// only the four channel kinds are known; every other code is refused
	assign type_known = (cfg_type == `FSS_SCT_MBX_OUT) | (cfg_type == `FSS_SCT_MBX_IN) |
	                    (cfg_type == `FSS_SCT_PD_OUT) | (cfg_type == `FSS_SCT_PD_IN); // RQ5
	assign cfg_bad    = cfg_check & (state_q == ST_PREOP) &
	                    (~type_known | ((cfg_type == `FSS_SCT_PD_OUT) & ~cfg_out_valid) |
	                     ((cfg_type == `FSS_SCT_PD_IN) & ~cfg_in_valid));
	assign tmo_masked = sync_err | wdog_hit | cfg_bad;

	// ---------------------------------------------------------------
	// edge capture of the timeouts so each raises once
	// ---------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_stale_q   <= 1'b0;
			tx_stale_q   <= 1'b0;
			wdog_stale_q <= 1'b0;
		end else begin
			rx_stale_q   <= rx_stale & ~(rx_rise & tmo_masked);
			tx_stale_q   <= tx_stale & ~(tx_rise & (tmo_masked | rx_rise));
			wdog_stale_q <= wdog_stale;
		end
	end

	// ---------------------------------------------------------------
	// error selection and fallback, highest priority last
	// ---------------------------------------------------------------
	always @* begin
		state_d = state_q;
		raise   = 1'b0;
		main_d  = `FSS_MAIN_81;
		sub_d   = 4'h0;
		if (req_valid && (req_state == ST_INIT || req_state == ST_PREOP ||
		    req_state == ST_SAFEOP || req_state == ST_OP))
			state_d = req_state;
		if (wait_preop && (state_q == ST_SAFEOP || state_q == ST_OP)) begin
			raise   = 1'b1;                     // RQ9
			main_d  = `FSS_MAIN_82;
			sub_d   = `FSS_SUB_WAIT_PREOP;
			state_d = state_q;
		end
		if (wait_init) begin
			raise   = 1'b1;                     // RQ8
			main_d  = `FSS_MAIN_82;
			sub_d   = `FSS_SUB_WAIT_INIT;
			state_d = state_q;
		end
		if (sync_err || tx_rise || rx_rise) begin
			raise  = 1'b1;
			main_d = `FSS_MAIN_81;
			if (sync_err)
				sub_d = `FSS_SUB_SYNC;          // RQ3
			else if (rx_rise)
				sub_d = `FSS_SUB_OUT_TMO;       // RQ1
			else
				sub_d = `FSS_SUB_IN_TMO;        // RQ10
			state_d = (state_q == ST_OP) ? ST_SAFEOP : state_q; // RQ2
		end
		if (wdog_hit) begin
			raise   = 1'b1;
			main_d  = `FSS_MAIN_81;
			sub_d   = `FSS_SUB_WDOG;
			state_d = ST_SAFEOP;                // RQ4
		end
		// a legal configuration leaves any lower-priority code untouched
		if (cfg_check && state_q == ST_PREOP) begin
			if (!type_known) begin
				raise   = 1'b1;
				main_d  = `FSS_MAIN_81;
				sub_d   = `FSS_SUB_SCTYPE;      // RQ5
				state_d = ST_INIT;
			end else if (cfg_type == `FSS_SCT_PD_OUT && !cfg_out_valid) begin
				raise   = 1'b1;
				main_d  = `FSS_MAIN_81;
				sub_d   = `FSS_SUB_OUTCFG;      // RQ6
				state_d = ST_INIT;
			end else if (cfg_type == `FSS_SCT_PD_IN && !cfg_in_valid) begin
				raise   = 1'b1;
				main_d  = `FSS_MAIN_81;
				sub_d   = `FSS_SUB_INCFG;       // RQ7
				state_d = ST_INIT;
			end
		end
	end

	// ---------------------------------------------------------------
	// state and error registers
	// ---------------------------------------------------------------
	// a new error wins over an acknowledge in the same cycle
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q      <= ST_INIT;
			err_active_q <= 1'b0;
			err_main_q   <= 8'h00;
			err_sub_q    <= 4'h0;
			err_prefix_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (raise) begin
				err_active_q <= 1'b1;
				err_main_q   <= main_d;         // RQ11
				err_sub_q    <= sub_d;
				err_prefix_q <= 1'b1;
			end else if (err_ack) begin
				err_active_q <= 1'b0;
				err_prefix_q <= 1'b0;
			end
		end
	end
endmodule // fss_supervisor

// ===== tb/fss_props.sv
`timescale 1ns/100ps
module fss_props #(
	parameter WDOG_CYC = 10
) (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       req_valid,
	input wire logic [3:0] req_state,
	input wire logic       rx_pd_update,
	input wire logic       dc_event,
	input wire logic       cfg_check,
	input wire logic [2:0] cfg_type,
	input wire logic       cfg_out_valid,
	input wire logic       cfg_in_valid,
	input wire logic       wait_init,
	input wire logic       wait_preop,
	input wire logic [3:0] state_q,
	input wire logic       err_active_q,
	input wire logic [7:0] err_main_q,
	input wire logic [3:0] err_sub_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// quiet cycles in op; saturates so a stuck op cannot wrap back to legal
	logic [7:0] quiet_q;
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n) quiet_q <= 8'h00;
		else if (rx_pd_update || state_q != 4'h8) quiet_q <= 8'h00;
		else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
	sequence s_rx_twice;
		rx_pd_update && !dc_event ##1 rx_pd_update && !dc_event;
	endsequence
	sequence s_dc_twice;
		dc_event && !rx_pd_update ##1 (!rx_pd_update && !dc_event) [*3] ##1 dc_event && !rx_pd_update;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_reset_init: assert property ($rose(reset_n) |-> state_q == 4'h1 && !err_active_q)
		else $error("bad state after reset");
	a_req_preop: assert property (state_q == 4'h1 && req_valid && req_state == 4'h2 && !wait_init && !wait_preop
		|=> state_q == 4'h2) else $error("preop request lost");
	a_rx_pairing: assert property (s_rx_twice |=> err_active_q && state_q != 4'h8)
		else $error("double data not flagged");
	a_dc_pairing: assert property (s_dc_twice |=> err_active_q && state_q != 4'h8)
		else $error("double event not flagged");
	a_wdog_drop: assert property (quiet_q > WDOG_CYC + 3 |-> state_q != 4'h8)
		else $error("watchdog missed");
	a_outcfg_init: assert property (state_q == 4'h2 && cfg_check && cfg_type == 3'h2 && !cfg_out_valid
		|=> state_q == 4'h1 && {err_main_q, err_sub_q} == 12'h81d) else $error("out config kept");
	a_incfg_init: assert property (state_q == 4'h2 && cfg_check && cfg_type == 3'h3 && !cfg_in_valid
		|=> state_q == 4'h1 && {err_main_q, err_sub_q} == 12'h81e) else $error("in config kept");
	a_type_init: assert property (state_q == 4'h2 && cfg_check && cfg_type[2]
		|=> state_q == 4'h1 && {err_main_q, err_sub_q} == 12'h81c) else $error("unknown type kept");
	a_wait_hold: assert property (wait_init && !cfg_check && state_q != 4'h8 |=> $stable(state_q))
		else $error("state moved while waiting");
	a_preop_hold: assert property (wait_preop && state_q == 4'h4 |=> state_q == 4'h4)
		else $error("safe state left while waiting");
endmodule // fss_props
bind fss_supervisor fss_props #(.WDOG_CYC(WDOG_CYC)) u_props (.ref_clk, .reset_n, .req_valid, .req_state,
	.rx_pd_update, .dc_event, .cfg_check, .cfg_type, .cfg_out_valid, .cfg_in_valid, .wait_init, .wait_preop,
	.state_q, .err_active_q, .err_main_q, .err_sub_q);

// ===== tb/fss_master_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// master traffic: clock event, then data, period 4
// ----------------------------------------
module fss_master_model (
	input  wire logic       ref_clk,
	input  wire logic       run,
	input  wire logic [1:0] fault,
	output logic            rx_pd_update,
	output logic            tx_pd_update,
	output logic            dc_event
);
	logic [1:0] ph_q = 2'h0;
	initial {rx_pd_update, tx_pd_update, dc_event} = 3'h0;
	// run and fault are taken at the edge and the strobes move 1 ns later,
	// so a bench change made just after an edge is seen one edge on
	// fault 1 sends data in the event slot, fault 2 drops the data
	always @(posedge ref_clk) begin
		ph_q <= ph_q + {1'b0, run};
		dc_event <= #1 run && ph_q == 2'h1 && fault != 2'h1;
		rx_pd_update <= #1 run && (ph_q == 2'h2 && fault != 2'h2 || ph_q == 2'h1 && fault == 2'h1);
		tx_pd_update <= #1 run && ph_q == 2'h2;
	end
endmodule // fss_master_model

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic       ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, cfg_check = 1'b0, err_ack = 1'b0;
	logic       cfg_out_valid = 1'b1, cfg_in_valid = 1'b1, wait_init = 1'b0, wait_preop = 1'b0, run = 1'b1;
	logic [3:0] req_state = 4'h0;
	logic [2:0] cfg_type = 3'h0;
	logic [1:0] fault = 2'h0;
	wire        rx, tx, dc, act, pre;
	wire  [3:0] st, sub;
	wire  [7:0] mn;
	int         err_count = 0, n_compared = 0, cyc = 0, exp_st = 1, v;
	always #20 ref_clk = ~ref_clk;
	fss_master_model u_mst (.ref_clk, .run, .fault, .rx_pd_update(rx), .tx_pd_update(tx), .dc_event(dc));
	fss_supervisor #(.TIMEOUT_CYC(20), .WDOG_CYC(10)) DUT (.ref_clk, .reset_n, .req_valid, .req_state,
		.rx_pd_update(rx), .tx_pd_update(tx), .dc_event(dc), .cfg_check, .cfg_type, .cfg_out_valid,
		.cfg_in_valid, .wait_init, .wait_preop, .err_ack, .state_q(st), .err_active_q(act), .err_main_q(mn),
		.err_sub_q(sub), .err_prefix_q(pre));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic code(input logic [11:0] c);
		chk({pre, act, 2'h0, mn, sub}, {4'hc, c});
	endtask
	// requests move the model only when no wait flag holds the state
	task automatic req(input logic [3:0] s);
		req_valid = 1'b1;
		req_state = s;
		step(1);
		req_valid = 1'b0;
		if (!wait_init && !wait_preop && s inside {1, 2, 4, 8}) exp_st = s;
		chk(st, exp_st);
	endtask
	// codes above 3 are refused, and so is a process-data channel with a bad config
	task automatic cfg(input logic [2:0] t, input logic ok);
		cfg_check = 1'b1;
		cfg_type = t;
		{cfg_out_valid, cfg_in_valid} = {ok, ok};
		step(1);
		cfg_check = 1'b0;
		if (t[2] || (!ok && t[1])) exp_st = 1;
		chk(st, exp_st);
	endtask
	task automatic ack;
		err_ack = 1'b1;
		step(1);
		err_ack = 1'b0;
		chk(act, 1'b0);
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		v = $urandom(91);
		step(16);
		reset_n = 1'b1;
		chk({pre, act, st}, 6'h01);
		req(4'h2);
		// non one-hot codes must be ignored
		repeat (4) req(4'(($urandom % 5) * 2 + 5));
		for (int t = 0; t < 4; t++) cfg(3'(t), 1'b1);
		cfg(3'h2, 1'b0);
		code(12'h81d);
		req(4'h2);
		cfg(3'h3, 1'b0);
		code(12'h81e);
		req(4'h2);
		req(4'h4);
		req(4'h8);
		fault = 2'h1;
		step(6);
		fault = 2'h0;
		exp_st = 4;
		chk(st, exp_st);
		code(12'h81a);
		ack();
		// a lost data refresh shows as two events in a row
		fault = 2'h2;
		step(10);
		fault = 2'h0;
		// the first event after the fault still finds no data; let it pass
		step(4);
		chk(st, exp_st);
		code(12'h81a);
		ack();
		req(4'h8);
		run = 1'b0;
		step(14);
		exp_st = 4;
		chk(st, exp_st);
		code(12'h81b);
		// both data timers expire together; the input error follows a cycle later
		step(6);
		code(12'h819);
		step(1);
		code(12'h818);
		chk(st, exp_st);
		run = 1'b1;
		step(8);
		ack();
		wait_preop = 1'b1;
		req(4'h1);
		code(12'h822);
		wait_init = 1'b1;
		req(4'h2);
		code(12'h821);
		{wait_init, wait_preop} = 2'h0;
		req(4'h1);
		// a random code outside the four channel kinds is refused in preop
		req(4'h2);
		cfg(3'(4 + $urandom % 4), 1'b1);
		code(12'h81c);
		conclude();
	end
endmodule // tb
